// ===== pkg/sgd_pkg.sv
// Constants, encodings and carriers of the management/graphics decoder
package sgd_pkg;
    localparam logic [31:0] SGD_COMPAT_LO = 32'h000a_0000;
    localparam logic [31:0] SGD_COMPAT_HI = 32'h000b_ffff;
    localparam logic [31:0] SGD_HIGH_LO = 32'hfeda_0000;
    localparam logic [31:0] SGD_HIGH_HI = 32'hfedb_ffff;
    localparam logic [31:0] SGD_HIGH_DELTA = 32'hfed0_0000;
    localparam logic [31:0] SGD_MDA_LO = 32'h000b_0000;
    localparam logic [31:0] SGD_MDA_HI = 32'h000b_7fff;
    localparam logic [31:0] SGD_MGMT_TOP_SEGMENT_1MB = 32'h0010_0000;
    localparam logic [31:0] SGD_MGMT_TOP_SEGMENT_2MB = 32'h0020_0000;
    localparam logic [31:0] SGD_MGMT_TOP_SEGMENT_8MB = 32'h0080_0000;
    localparam logic [1:0] SGD_MGMT_TOP_SEGMENT_SEL_1MB = 2'h0;
    localparam logic [1:0] SGD_MGMT_TOP_SEGMENT_SEL_2MB = 2'h1;
    localparam logic [1:0] SGD_MGMT_TOP_SEGMENT_SEL_8MB = 2'h2;
    // Config offset of the control-window base register
    localparam logic [7:0] SGD_CTL_BASE_CFG_OFFSET = 8'h14;
    localparam logic [31:0] SGD_CTL_VGA_HI = 32'h0000_0fff;
    localparam logic [31:0] SGD_CTL_INSTR_LO = 32'h0000_1000;
    localparam logic [31:0] SGD_CTL_INSTR_HI = 32'h0000_2fff;
    localparam logic [15:0] SGD_IO_INDEX_OFF = 16'h0000;
    localparam logic [15:0] SGD_IO_DATA_OFF = 16'h0004;
    localparam logic [15:0] SGD_VGA_IO_LO = 16'h03b0;
    localparam logic [15:0] SGD_VGA_IO_HI = 16'h03df;
    localparam logic [15:0] SGD_MONO_IO_HI = 16'h03bf;
    localparam int SGD_GFX_WINDOWS = 3;
    localparam logic [1:0] SGD_WIN_CTL = 2'h0;
    localparam logic [1:0] SGD_WIN_APERTURE = 2'h1;
    localparam logic [1:0] SGD_WIN_TABLE = 2'h2;

    typedef enum logic [1:0] {
        SGD_ORG_CPU = 2'h0,
        SGD_ORG_GPORT = 2'h1,
        SGD_ORG_HUB = 2'h2
    } sgd_origin_e;

    typedef enum logic [2:0] {
        SGD_TGT_NONE = 3'h0,
        SGD_TGT_DRAM = 3'h1,
        SGD_TGT_GFX = 3'h2,
        SGD_TGT_GPORT = 3'h3,
        SGD_TGT_HUB = 3'h4,
        SGD_TGT_ABORT = 3'h5
    } sgd_target_e;

    typedef enum logic [1:0] {
        SGD_ST_IDLE = 2'h0,
        SGD_ST_WAIT = 2'h1
    } sgd_state_e;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
        sgd_origin_e origin;
        logic write;
        logic code;
        logic smm;
        logic req1N;
    } sgd_mem_req_s;

    typedef struct packed {
        logic globalEn;
        logic highEn;
        logic topSegEn;
        logic [1:0] topSegSize;
        logic openBit;
        logic closeBit;
        logic lockBit;
    } sgd_mgmt_cfg_s;

    typedef struct packed {
        logic valid;
        sgd_target_e target;
        logic [31:0] addr;
        logic [1:0] window;
    } sgd_route_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] addr;
        logic [31:0] wdata;
    } sgd_io_req_s;

    typedef struct packed {
        logic valid;
        logic claimed;
        logic [31:0] rdata;
    } sgd_io_rsp_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] offset;
        logic [31:0] wdata;
    } sgd_fwd_req_s;
endpackage

// ===== rtl/sgd_range_cmp.sv
// Inclusive address range comparator
`timescale 1ns/1ps
`default_nettype none
module sgd_range_cmp #(
    parameter int W = 32
) (
    input wire logic [W-1:0] lo,
    input wire logic [W-1:0] hi,
    input wire logic [W-1:0] addr,
    output logic hit
);
    assign hit = (addr >= lo) && (addr <= hi);
endmodule
`default_nettype wire

// ===== rtl/sgd_index_port.sv
// Indexed and legacy I/O access to the graphics control window
`timescale 1ns/1ps
`default_nettype none
module sgd_index_port (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic monoPresent,
    input wire logic [15:0] ioBase,
    input wire sgd_pkg::sgd_io_req_s ioReq,
    output logic ioReady,
    output sgd_pkg::sgd_io_rsp_s ioRsp,
    output sgd_pkg::sgd_fwd_req_s fwdReq,
    input wire logic fwdDone,
    input wire logic [31:0] fwdRdata
);
    sgd_pkg::sgd_state_e state_q, state_d;
    logic [31:0] pointer_q, pointer_d;
    sgd_pkg::sgd_io_rsp_s rsp_q, rsp_d;
    sgd_pkg::sgd_fwd_req_s fwd_q, fwd_d;
    logic take, hitIdx, hitDat, hitVga;

    assign ioReady = (state_q == sgd_pkg::SGD_ST_IDLE);
    assign take = ioReq.valid && ioReady;
    assign hitIdx = enable && (ioReq.addr == ioBase + sgd_pkg::SGD_IO_INDEX_OFF);
    assign hitDat = enable && (ioReq.addr == ioBase + sgd_pkg::SGD_IO_DATA_OFF);
    // Mono ports belong to the second adapter when it is present
    assign hitVga = enable && (ioReq.addr >= sgd_pkg::SGD_VGA_IO_LO)
        && (ioReq.addr <= sgd_pkg::SGD_VGA_IO_HI)
        && !(monoPresent && ioReq.addr <= sgd_pkg::SGD_MONO_IO_HI);

    always_comb begin
        state_d = state_q;
        pointer_d = pointer_q;
        rsp_d = '0;
        fwd_d = fwd_q;
        case (state_q)
            sgd_pkg::SGD_ST_IDLE: begin
                if (take) begin
                    if (hitIdx) begin
                        rsp_d.valid = 1'b1;
                        rsp_d.claimed = 1'b1;
                        if (ioReq.write) begin
                            pointer_d = ioReq.wdata;
                        end else begin
                            rsp_d.rdata = pointer_q;
                        end
                    end else if (hitDat || hitVga) begin
                        fwd_d.valid = 1'b1;
                        fwd_d.write = ioReq.write;
                        fwd_d.wdata = ioReq.wdata;
                        // Legacy ports land in the low VGA offsets only
                        fwd_d.offset = hitDat ? pointer_q
                            : {16'h0000, ioReq.addr};
                        state_d = sgd_pkg::SGD_ST_WAIT;
                    end else begin
                        rsp_d.valid = 1'b1;
                    end
                end
            end
            sgd_pkg::SGD_ST_WAIT: begin
                if (fwdDone) begin
                    fwd_d = '0;
                    rsp_d.valid = 1'b1;
                    rsp_d.claimed = 1'b1;
                    rsp_d.rdata = fwd_q.write ? 32'h0000_0000 : fwdRdata;
                    state_d = sgd_pkg::SGD_ST_IDLE;
                end
            end
            default: begin
                fwd_d = '0;
                state_d = sgd_pkg::SGD_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= sgd_pkg::SGD_ST_IDLE;
            pointer_q <= 32'h0000_0000;
            rsp_q <= '0;
            fwd_q <= '0;
        end else begin
            state_q <= state_d;
            pointer_q <= pointer_d;
            rsp_q <= rsp_d;
            fwd_q <= fwd_d;
        end
    end

    assign ioRsp = rsp_q;
    assign fwdReq = fwd_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_idx_write;
        take && hitIdx && ioReq.write;
    endsequence

    sequence s_idx_read;
        take && hitIdx && !ioReq.write;
    endsequence

    a_index_readback: assert property (
        (s_idx_write ##1 !take ##1 s_idx_read) |=> ioRsp.valid
            && (ioRsp.rdata == $past(pointer_q))
            && (pointer_q == $past(ioReq.wdata, 3)))
        else $error("index read does not return the written offset");

    a_disabled_gate: assert property (
        (take && !enable) |=> !fwdReq.valid && !ioRsp.claimed)
        else $error("indexed access claimed while graphics disabled");

    a_data_forward: assert property (
        (take && hitDat && !hitIdx) |=> fwdReq.valid
            && (fwdReq.offset == $past(pointer_q)))
        else $error("data port not forwarded at held offset");
endmodule
`default_nettype wire

// ===== rtl/sgd_decoder.sv
// Management RAM and graphics window decoder with indexed I/O access
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - CPU hits in graphics windows go to graphics when device and function enabled
// - Control-window offsets relative to its base register
// - VGA sets at legacy I/O and low offsets
// - Instruction/interrupt offsets also reachable through the data port
// - Indexed access needs device and function enabled
// - Index port holds and returns written offset
// - Data port accesses register selected by index
// - Top segment 1/2/8 MB below graphics memory
// - Compatible and top segment are not remapped
// - High window remaps onto compatible DRAM
// - Global, high and segment enables select ranges
// - Compatible range under high window follows VGA
// - Only processor may reach management memory
// - Global enable clear denies all management access
// - Open unlocked with close clear grants access outside management mode
// - Lock ignores open; management mode only
// - Close sends data away, code still DRAM
// - Processor writebacks always reach management DRAM
// - Shadow reads and writes routed separately
// - No translation for graphics port requests
// - Denied high window access terminates immediately
module sgd_decoder (
    input wire logic clk,
    input wire logic rst_n,
    input wire sgd_pkg::sgd_mem_req_s memReq,
    input wire sgd_pkg::sgd_mgmt_cfg_s mgmtCfg,
    input wire logic [31:0] topOfLowDram,
    input wire logic [31:0] stolenSize,
    input wire logic legacyVgaRouteEnable,
    input wire logic monoAdapterPresent,
    input wire logic gfxDevEnable,
    input wire logic gfxFuncEnable,
    input wire logic [2:0][31:0] gfxWinBase,
    input wire logic [2:0][31:0] gfxWinMask,
    input wire logic [31:0] shadowLo,
    input wire logic [31:0] shadowHi,
    input wire logic shadowReadDram,
    input wire logic shadowWriteDram,
    output sgd_pkg::sgd_route_s memRoute,
    input wire logic [15:0] gfxIndexedIoBase,
    input wire sgd_pkg::sgd_io_req_s ioReq,
    output logic ioReady,
    output sgd_pkg::sgd_io_rsp_s ioRsp,
    output sgd_pkg::sgd_fwd_req_s fwdReq,
    input wire logic fwdDone,
    input wire logic [31:0] fwdRdata
);
    localparam int SGD_GFX_WINDOWS = sgd_pkg::SGD_GFX_WINDOWS;
    sgd_pkg::sgd_route_s route_q, route_d;
    logic gfxOn, isCpu, writeback;
    logic compEn, highEn, segEn;
    logic inComp, inHigh, inSeg, inMda, inShadow;
    logic hitComp, hitHigh, hitSeg, mgmtHit;
    logic codeOk, dataOk, allow;
    logic [31:0] segBytes, segTop, segLo, segHi;
    logic [SGD_GFX_WINDOWS-1:0] winHit;
    logic [1:0] winSel;
    logic [31:0] winOffset;
    sgd_pkg::sgd_target_e legacyTarget;

    assign gfxOn = gfxDevEnable && gfxFuncEnable;
    assign isCpu = (memReq.origin == sgd_pkg::SGD_ORG_CPU);
    assign writeback = !memReq.req1N;

    // Range enables
    assign compEn = mgmtCfg.globalEn && !mgmtCfg.highEn;
    assign highEn = mgmtCfg.globalEn && mgmtCfg.highEn;
    assign segEn = mgmtCfg.globalEn && mgmtCfg.topSegEn;

    always_comb begin
        case (mgmtCfg.topSegSize)
            sgd_pkg::SGD_MGMT_TOP_SEGMENT_SEL_1MB: segBytes = sgd_pkg::SGD_MGMT_TOP_SEGMENT_1MB;
            sgd_pkg::SGD_MGMT_TOP_SEGMENT_SEL_2MB: segBytes = sgd_pkg::SGD_MGMT_TOP_SEGMENT_2MB;
            sgd_pkg::SGD_MGMT_TOP_SEGMENT_SEL_8MB: segBytes = sgd_pkg::SGD_MGMT_TOP_SEGMENT_8MB;
            default: segBytes = 32'h0000_0000;
        endcase
    end

    // Segment sits directly under the memory stolen for graphics
    assign segTop = topOfLowDram - stolenSize;
    assign segLo = segTop - segBytes;
    assign segHi = segTop - 32'h0000_0001;

    sgd_range_cmp #(.W(32)) u_comp (
        .lo(sgd_pkg::SGD_COMPAT_LO),
        .hi(sgd_pkg::SGD_COMPAT_HI),
        .addr(memReq.addr),
        .hit(inComp)
    );

    sgd_range_cmp #(.W(32)) u_high (
        .lo(sgd_pkg::SGD_HIGH_LO),
        .hi(sgd_pkg::SGD_HIGH_HI),
        .addr(memReq.addr),
        .hit(inHigh)
    );

    sgd_range_cmp #(.W(32)) u_seg (
        .lo(segLo),
        .hi(segHi),
        .addr(memReq.addr),
        .hit(inSeg)
    );

    sgd_range_cmp #(.W(32)) u_mda (
        .lo(sgd_pkg::SGD_MDA_LO),
        .hi(sgd_pkg::SGD_MDA_HI),
        .addr(memReq.addr),
        .hit(inMda)
    );

    sgd_range_cmp #(.W(32)) u_shadow (
        .lo(shadowLo),
        .hi(shadowHi),
        .addr(memReq.addr),
        .hit(inShadow)
    );

    genvar gi;
    generate
        for (gi = 0; gi < SGD_GFX_WINDOWS; gi++) begin : g_win
            sgd_range_cmp #(.W(32)) u_win (
                .lo(gfxWinBase[gi]),
                .hi(gfxWinBase[gi] | gfxWinMask[gi]),
                .addr(memReq.addr),
                .hit(winHit[gi])
            );
        end
    endgenerate

    assign hitComp = compEn && inComp;
    assign hitHigh = highEn && inHigh;
    assign hitSeg = segEn && inSeg && (segBytes != 32'h0000_0000);
    assign mgmtHit = hitComp || hitHigh || hitSeg;

    // Open together with close is left denied rather than guessed at
    assign codeOk = mgmtCfg.globalEn && (memReq.smm
        || (!mgmtCfg.lockBit && mgmtCfg.openBit && !mgmtCfg.closeBit));
    assign dataOk = mgmtCfg.globalEn
        && ((memReq.smm && !mgmtCfg.closeBit)
        || (!mgmtCfg.lockBit && mgmtCfg.openBit && !mgmtCfg.closeBit));
    assign allow = memReq.code ? codeOk : dataOk;

    // Legacy VGA memory: second adapter keeps its mono hole
    assign legacyTarget = (legacyVgaRouteEnable
        && !(monoAdapterPresent && inMda))
        ? sgd_pkg::SGD_TGT_GPORT : sgd_pkg::SGD_TGT_HUB;

    always_comb begin
        winSel = sgd_pkg::SGD_WIN_CTL;
        if (winHit[sgd_pkg::SGD_WIN_TABLE]) begin
            winSel = sgd_pkg::SGD_WIN_TABLE;
        end
        if (winHit[sgd_pkg::SGD_WIN_APERTURE]) begin
            winSel = sgd_pkg::SGD_WIN_APERTURE;
        end
        if (winHit[sgd_pkg::SGD_WIN_CTL]) begin
            winSel = sgd_pkg::SGD_WIN_CTL;
        end
    end

    assign winOffset = memReq.addr - gfxWinBase[winSel];

    always_comb begin
        route_d = '0;
        route_d.valid = memReq.valid;
        route_d.addr = memReq.addr;
        if (!memReq.valid) begin
            route_d.target = sgd_pkg::SGD_TGT_NONE;
        end else if (isCpu && mgmtHit) begin
            if (allow || writeback) begin
                route_d.target = sgd_pkg::SGD_TGT_DRAM;
                if (hitHigh) begin
                    route_d.addr = memReq.addr
                        - sgd_pkg::SGD_HIGH_DELTA;
                end
            end else if (hitHigh) begin
                route_d.target = sgd_pkg::SGD_TGT_ABORT;
            end else if (hitComp) begin
                route_d.target = legacyTarget;
            end else if (memReq.smm && mgmtCfg.closeBit) begin
                route_d.target = sgd_pkg::SGD_TGT_HUB;
            end else begin
                route_d.target = sgd_pkg::SGD_TGT_ABORT;
            end
        end else if (!isCpu && (hitHigh || hitSeg)) begin
            route_d.target = sgd_pkg::SGD_TGT_ABORT;
        end else if (inComp) begin
            // Compatible range off or non-CPU: plain VGA memory
            route_d.target = legacyTarget;
        end else if (isCpu && gfxOn && (|winHit)) begin
            route_d.target = sgd_pkg::SGD_TGT_GFX;
            route_d.window = winSel;
            route_d.addr = winOffset;
        end else if (isCpu && inShadow) begin
            // ROM reads during copy, DRAM reads once shadowed
            if (memReq.write) begin
                route_d.target = shadowWriteDram
                    ? sgd_pkg::SGD_TGT_DRAM : sgd_pkg::SGD_TGT_HUB;
            end else begin
                route_d.target = shadowReadDram
                    ? sgd_pkg::SGD_TGT_DRAM : sgd_pkg::SGD_TGT_HUB;
            end
        end else if (memReq.addr < topOfLowDram) begin
            route_d.target = sgd_pkg::SGD_TGT_DRAM;
        end else begin
            route_d.target = sgd_pkg::SGD_TGT_HUB;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            route_q <= '0;
        end else begin
            route_q <= route_d;
        end
    end

    assign memRoute = route_q;

    sgd_index_port u_index (
        .clk(clk),
        .rst_n(rst_n),
        .enable(gfxOn),
        .monoPresent(monoAdapterPresent),
        .ioBase(gfxIndexedIoBase),
        .ioReq(ioReq),
        .ioReady(ioReady),
        .ioRsp(ioRsp),
        .fwdReq(fwdReq),
        .fwdDone(fwdDone),
        .fwdRdata(fwdRdata)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_cpu_high_ok;
        memReq.valid && isCpu && hitHigh && allow;
    endsequence

    a_high_remap: assert property (
        s_cpu_high_ok |=> memRoute.target == sgd_pkg::SGD_TGT_DRAM
            && memRoute.addr == $past(memReq.addr) - 32'hfed0_0000)
        else $error("high window not remapped to compatible DRAM");

    a_foreign_block: assert property (
        (memReq.valid && !isCpu && (hitHigh || hitSeg))
            |=> memRoute.target == sgd_pkg::SGD_TGT_ABORT)
        else $error("non-processor request reached management range");

    a_global_off: assert property (
        (memReq.valid && !mgmtCfg.globalEn && isCpu && inHigh)
            |=> memRoute.target == sgd_pkg::SGD_TGT_HUB)
        else $error("management range decoded with global enable off");

    a_writeback_dram: assert property (
        (memReq.valid && isCpu && mgmtHit && !memReq.req1N)
            |=> memRoute.target == sgd_pkg::SGD_TGT_DRAM)
        else $error("writeback not sent to management DRAM");

    a_close_data: assert property (
        (memReq.valid && isCpu && hitComp && memReq.smm
            && mgmtCfg.closeBit && memReq.req1N)
            |=> (memRoute.target != sgd_pkg::SGD_TGT_DRAM)
            == !$past(memReq.code))
        else $error("close bit did not split code and data");

    a_lock_denies: assert property (
        (memReq.valid && isCpu && hitSeg && mgmtCfg.lockBit
            && !memReq.smm && memReq.req1N)
            |=> memRoute.target == sgd_pkg::SGD_TGT_ABORT)
        else $error("locked segment reached outside management mode");

    a_gfx_window: assert property (
        (memReq.valid && isCpu && gfxOn && !mgmtHit && !inComp
            && winHit[0])
            |=> memRoute.target == sgd_pkg::SGD_TGT_GFX
            && memRoute.addr == $past(memReq.addr) - $past(gfxWinBase[0]))
        else $error("control window hit not routed to graphics");

    a_compat_vga: assert property (
        (memReq.valid && isCpu && highEn && inComp && !inMda
            && legacyVgaRouteEnable)
            |=> memRoute.target == sgd_pkg::SGD_TGT_GPORT)
        else $error("compatible range not sent to graphics port");

    a_high_abort: assert property (
        (memReq.valid && isCpu && hitHigh && !memReq.smm && memReq.req1N
            && !(mgmtCfg.openBit && !mgmtCfg.lockBit))
            |=> memRoute.target == sgd_pkg::SGD_TGT_ABORT)
        else $error("denied high window access not terminated");

    a_open_grant: assert property (
        (memReq.valid && isCpu && hitComp && mgmtCfg.openBit
            && !mgmtCfg.lockBit && !mgmtCfg.closeBit)
            |=> memRoute.target == sgd_pkg::SGD_TGT_DRAM)
        else $error("open bit did not grant management access");

    a_seg_identity: assert property (
        (memReq.valid && isCpu && hitSeg && allow)
            |=> memRoute.target == sgd_pkg::SGD_TGT_DRAM
            && memRoute.addr == $past(memReq.addr))
        else $error("top segment access remapped or not sent to DRAM");
endmodule
`default_nettype wire

// ===== tb/sgd_gfx_reg_model.sv
// Graphics register space responder for forwarded index-port accesses
`timescale 1ns/1ps
`default_nettype none
module sgd_gfx_reg_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] lag,
    input wire sgd_pkg::sgd_fwd_req_s fwdReq,
    output logic fwdDone,
    output logic [31:0] fwdRdata,
    output logic [31:0] seenWdata
);
    logic [3:0] cnt;

    always @(posedge clk) begin
        fwdDone <= 1'b0;
        // Data lines toggle when idle so a stale value never looks valid
        fwdRdata <= ~fwdRdata;
        if (!rst_n) begin
            cnt <= 4'h0;
            fwdRdata <= 32'h0;
            seenWdata <= 32'h0;
        end else if (fwdReq.valid && !fwdDone) begin
            if (cnt == lag) begin
                fwdDone <= 1'b1;
                // Inverted offset lets the bench see which register was hit
                fwdRdata <= ~fwdReq.offset;
                cnt <= 4'h0;
                if (fwdReq.write)
                    seenWdata <= fwdReq.wdata;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/sgd_decoder_tb.sv
// Self-checking bench for the management and graphics decoder
`timescale 1ns/1ps
`default_nettype none
module sgd_decoder_tb;
    localparam logic [1:0] CPU = 2'h0, GPT = 2'h1, HUB = 2'h2;
    localparam logic [2:0] DR = 3'h1, GX = 3'h2, GP = 3'h3, HB = 3'h4;
    localparam logic [2:0] AB = 3'h5;
    localparam logic [3:0] SD = 4'h3, SC = 4'h7, ND = 4'h1, WB = 4'h8;
    localparam logic [3:0] NW = 4'h9;
    // Open and close are never set together
    localparam logic [7:0] BASE = 8'h98, HI = 8'hd8;
    localparam logic [31:0] CA = 32'h000a_8000;
    logic clk = 1'b0;
    logic rst_n;
    sgd_pkg::sgd_mem_req_s req;
    sgd_pkg::sgd_mgmt_cfg_s cfg;
    sgd_pkg::sgd_route_s route;
    sgd_pkg::sgd_io_req_s ioReq;
    sgd_pkg::sgd_io_rsp_s ioRsp;
    sgd_pkg::sgd_fwd_req_s fwdReq;
    logic [31:0] top_of_low_dram, stolen, shLo, shHi, fwdRdata, seenWdata;
    logic legacy_vga_route_enable, mono, devEn, funEn, shRd, shWr, ioReady, fwdDone;
    logic [2:0][31:0] winBase, winMask;
    logic [3:0] lag;
    int errTotal = 0;
    int compares = 0;
    int cyc = 0;

    sgd_decoder dut_u (.clk(clk), .rst_n(rst_n), .memReq(req), .mgmtCfg(cfg),
        .topOfLowDram(top_of_low_dram), .stolenSize(stolen),
        .legacyVgaRouteEnable(legacy_vga_route_enable), .monoAdapterPresent(mono),
        .gfxDevEnable(devEn), .gfxFuncEnable(funEn), .gfxWinBase(winBase),
        .gfxWinMask(winMask), .shadowLo(shLo), .shadowHi(shHi),
        .shadowReadDram(shRd), .shadowWriteDram(shWr), .memRoute(route),
        .gfxIndexedIoBase(16'h1000), .ioReq(ioReq), .ioReady(ioReady),
        .ioRsp(ioRsp), .fwdReq(fwdReq), .fwdDone(fwdDone),
        .fwdRdata(fwdRdata));
    sgd_gfx_reg_model modelU (.clk(clk), .rst_n(rst_n), .lag(lag),
        .fwdReq(fwdReq), .fwdDone(fwdDone), .fwdRdata(fwdRdata),
        .seenWdata(seenWdata));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic testDone;
        $display("compares %0d errors %0d", compares, errTotal);
        if (errTotal == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            errTotal++;
            testDone();
        end
    end

    task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            errTotal++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic cf(input logic [7:0] v);
        @(posedge clk);
        cfg <= v;
    endtask

    // Address is only defined for DRAM and graphics targets
    task automatic mem(input logic [31:0] a, input logic [1:0] o,
            input logic [3:0] f, input logic [2:0] t, input logic [31:0] ea);
        logic [31:0] ga;
        @(posedge clk);
        req <= {1'b1, a, o, f};
        @(posedge clk);
        req.valid <= 1'b0;
        #1;
        ga = (t == DR || t == GX) ? route.addr : ea;
        cmp({route.valid, route.target, ga}, {1'b1, t, ea});
    endtask

    task automatic io(input logic w, input logic [15:0] a,
            input logic [31:0] d, input logic [32:0] exp);
        logic seen;
        logic [31:0] gd;
        seen = 1'b0;
        @(posedge clk);
        ioReq <= {1'b1, w, a, d};
        @(posedge clk);
        ioReq.valid <= 1'b0;
        for (int i = 0; i < 20 && !seen; i++) begin
            #1;
            seen = (ioRsp.valid === 1'b1);
            if (!seen)
                @(posedge clk);
        end
        gd = (w || !exp[32]) ? exp[31:0] : ioRsp.rdata;
        cmp({seen, ioRsp.claimed, gd}, {1'b1, exp});
    endtask

    task automatic tCompat;
        @(posedge clk);
        devEn <= 1'b0;
        cf(BASE);
        mem(CA, CPU, SD, DR, CA);
        mem(32'h000b_ffff, CPU, SC, DR, 32'h000b_ffff);
        mem(CA, CPU, ND, HB, 0);
        cf(BASE | 8'h04);
        mem(CA, CPU, ND, DR, CA);
        mem(CA, HUB, NW, HB, 0);
        cf(BASE | 8'h05);
        mem(CA, CPU, ND, HB, 0);
        mem(CA, CPU, SD, DR, CA);
        cf(BASE | 8'h02);
        mem(CA, CPU, SD, HB, 0);
        mem(CA, CPU, SC, DR, CA);
        mem(CA, CPU, WB, DR, CA);
        cf(8'h1c);
        mem(CA, CPU, SC, HB, 0);
    endtask

    task automatic tHigh;
        cf(HI);
        mem(32'hfeda_1234, CPU, SD, DR, 32'h000a_1234);
        mem(32'hfedb_ffff, CPU, SC, DR, 32'h000b_ffff);
        mem(32'hfedc_0000, CPU, SD, HB, 0);
        mem(32'hfeda_0000, CPU, ND, AB, 0);
        mem(32'hfeda_0040, CPU, WB, DR, 32'h000a_0040);
        mem(32'hfeda_0000, GPT, NW, AB, 0);
        mem(CA, CPU, SD, HB, 0);
        @(posedge clk);
        legacy_vga_route_enable <= 1'b1;
        mem(CA, CPU, SD, GP, 0);
        @(posedge clk);
        mono <= 1'b1;
        mem(32'h000b_1000, CPU, SD, HB, 0);
        @(posedge clk);
        legacy_vga_route_enable <= 1'b0;
        mono <= 1'b0;
        cf(8'h58);
        mem(32'hfeda_1234, CPU, SD, HB, 0);
    endtask

    task automatic mgmt_top_segment;
        logic [31:0] sz [3];
        logic [31:0] lo;
        sz = '{sgd_pkg::SGD_MGMT_TOP_SEGMENT_1MB, sgd_pkg::SGD_MGMT_TOP_SEGMENT_2MB,
            sgd_pkg::SGD_MGMT_TOP_SEGMENT_8MB};
        for (int i = 0; i < 3; i++) begin
            cf({3'b101, i[1:0], 3'b000});
            lo = top_of_low_dram - stolen - sz[i];
            mem(lo, CPU, ND, AB, 0);
            mem(lo - 1, CPU, ND, DR, lo - 1);
            mem(lo, CPU, SD, DR, lo);
            mem(top_of_low_dram - stolen - 1, CPU, SD, DR, top_of_low_dram - stolen - 1);
        end
        mem(lo, HUB, ND, AB, 0);
        cf(8'hb5);
        mem(lo, CPU, ND, AB, 0);
    endtask

    task automatic tGfx;
        @(posedge clk);
        devEn <= 1'b1;
        cf(BASE);
        for (int i = 0; i < 3; i++) begin
            mem(winBase[i] | winMask[i], CPU, ND, GX, winMask[i]);
            cmp(route.window, i[1:0]);
        end
        mem(32'he000_1000, CPU, NW, GX, 32'h0000_1000);
        mem(32'he008_0000, CPU, ND, HB, 0);
        mem(32'hd000_0000, GPT, ND, HB, 0);
        @(posedge clk);
        devEn <= 1'b0;
        mem(32'hd000_0000, CPU, ND, HB, 0);
        @(posedge clk);
        devEn <= 1'b1;
    endtask

    task automatic tShadow;
        mem(32'h000e_0100, CPU, ND, HB, 0);
        mem(32'h000e_0100, CPU, NW, DR, 32'h000e_0100);
        @(posedge clk);
        shRd <= 1'b1;
        mem(32'h000e_0100, CPU, ND, DR, 32'h000e_0100);
    endtask

    task automatic tIo;
        io(1'b1, 16'h1000, 32'h0000_1004, {1'b1, 32'h0});
        io(1'b0, 16'h1000, 0, {1'b1, 32'h0000_1004});
        io(1'b0, 16'h1004, 0, {1'b1, ~32'h0000_1004});
        io(1'b1, 16'h1004, 32'h1234_5678, {1'b1, 32'h0});
        cmp(seenWdata, 32'h1234_5678);
        @(posedge clk) lag <= 4'h0;
        io(1'b0, 16'h03c0, 0, {1'b1, ~32'h0000_03c0});
        @(posedge clk) mono <= 1'b1;
        io(1'b0, 16'h03b4, 0, {1'b0, 32'h0});
        @(posedge clk) funEn <= 1'b0;
        io(1'b0, 16'h1004, 0, {1'b0, 32'h0});
        io(1'b0, 16'h1000, 0, {1'b0, 32'h0});
    endtask

    initial begin
        rst_n = 1'b0;
        req = '0;
        cfg = BASE;
        top_of_low_dram = 32'h0400_0000;
        stolen = 32'h0010_0000;
        {legacy_vga_route_enable, mono, devEn, funEn, shRd, shWr} = 6'b001101;
        winBase = {32'he010_0000, 32'hd000_0000, 32'he000_0000};
        winMask = {32'h000f_ffff, 32'h0fff_ffff, 32'h0007_ffff};
        shLo = 32'h000e_0000;
        shHi = 32'h000e_ffff;
        ioReq = '0;
        lag = 4'h3;
        repeat (8) @(posedge clk);
        #1;
        cmp({route.valid, ioRsp.valid, fwdReq.valid, ioReady}, 4'h1);
        @(posedge clk);
        rst_n <= 1'b1;
        tCompat();
        tHigh();
        mgmt_top_segment();
        tGfx();
        tShadow();
        tIo();
        testDone();
    end
endmodule
`default_nettype wire
